// ==== rtl/efc_defs.svh ====
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH
// What this block does
// - codebook gain blends previous with target
// - excitation gain ramps linearly across frame
// - harmonic gain target is zero
// - noise target made in first loss, held
// - raw target is sqrt of scaled bin sum
// - raw target scaled by mean subframe energy
// - each envelope blends previous with target
// - innovative envelope damping at least 0.8
// - harmonic envelope target is mean of three
// - squared spectrum transformed into 17 lags
// - normalise lags, floor lag zero, scale
// - order-16 recursion gives innovative envelope
// - unvoiced coder, short loss: damping one
// - unpitched class: 0.8+0.2s, 0.6, 0.4
// - unpitched transition or short generic onset: 0.8
// - periodic or short onset: one, else 0.4
// - first loss scales by clamped root gain
// - second loss uses (0.6+0.35s) times gain
// - later losses decay pitch gain, then scale
// - other core: stability based three stages

// ==================================================
// fixed point q2.14, one is 16'h4000
`define EFC_ONE 16'h4000
`define EFC_A080 16'h3333
`define EFC_A020 16'h0CCD
`define EFC_A060 16'h2666
`define EFC_A040 16'h199A
`define EFC_A035 16'h1666
`define EFC_A070 16'h2CCD
`define EFC_A030 16'h1333
`define EFC_A045 16'h1CCD
`define EFC_SQ_MIN 16'h3666
`define EFC_SQ_MAX 16'h3EB8

// ==================================================
// counts and figures
`define EFC_SHORT_LOSS 4'h3
`define EFC_CNT_MAX 4'hF
`define EFC_NOISE_NUM 64'h140
`define EFC_R0_MIN 32'h64
`define EFC_R0_DIV 32'h7D0
`define EFC_HIST_LEN 18'h3
`define EFC_COEF_ONE 32'h4000
`endif

// ==== rtl/efc_pkg.sv ====
package efc_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_alpha = 3'h1,
    st_spec = 3'h2,
    st_noise = 3'h3,
    st_leva = 3'h4,
    st_levk = 3'h5,
    st_lsfw = 3'h6,
    st_apply = 3'h7
  } efc_state_t;
  typedef enum logic [2:0] {
    unpitched_frame_class = 3'h0,
    unpitched_trans_class = 3'h1,
    voiced_trans_class = 3'h2,
    periodic_frame_class = 3'h3,
    onset_class = 3'h4,
    other_class = 3'h5
  } efc_class_t;
  typedef enum logic [1:0] {
    coder_generic = 2'h0,
    coder_unvoiced = 2'h1,
    coder_voiced = 2'h2,
    coder_other = 2'h3
  } efc_coder_t;
endpackage

// ==== rtl/efc_fade.sv ====
`timescale 1ns/1ps
`include "efc_defs.svh"
module efc_fade #(
  parameter int ORD = 16,
  parameter int FRAME_LEN = 256,
  parameter int NSUB = 4,
  parameter int NORM_SHIFT = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_start,
  input wire logic frame_lost,
  input wire logic code_excited_core,
  input wire efc_pkg::efc_class_t last_class,
  input wire efc_pkg::efc_coder_t coder_type,
  input wire logic [15:0] stability,
  input wire logic [15:0] pitch_gain_in,
  input wire logic [1:0][15:0] gain_in,
  input wire logic [ORD-1:0][15:0] lsf_in,
  input wire logic [NSUB-1:0][15:0] subfr_energy,
  input wire logic [15:0] first_noise_bin,
  input wire logic [15:0] last_noise_bin,
  input wire logic bin_valid,
  input wire logic bin_last,
  input wire logic [15:0] bin_index,
  input wire logic [15:0] bin_value,
  input wire logic [ORD:0][15:0] bin_cos,
  input wire logic lsf_tgt_valid,
  input wire logic [ORD-1:0][15:0] lsf_tgt_in,
  input wire logic exc_valid,
  input wire logic [15:0] exc_harm,
  input wire logic [15:0] exc_inno,
  output logic [3:0] lost_count,
  output logic [15:0] alpha,
  output logic [15:0] pitch_gain,
  output logic [15:0] gain_harm,
  output logic [15:0] gain_inno,
  output logic [15:0] gain_target,
  output logic [ORD-1:0][15:0] lsf_harm,
  output logic [ORD-1:0][15:0] lsf_inno,
  output logic [ORD:0][31:0] lpc_coef,
  output logic lpc_valid,
  output logic frame_done,
  output logic fade_valid,
  output logic [15:0] fade_harm,
  output logic [15:0] fade_inno
);
  typedef struct packed {
    efc_pkg::efc_state_t fsm;
    logic [3:0] cnt;
    efc_pkg::efc_class_t cls;
    efc_pkg::efc_coder_t ctype;
    logic celp;
    logic [15:0] theta;
    logic [15:0] gp;
    logic [15:0] alpha;
    logic [1:0][15:0] g_prev;
    logic [1:0][15:0] g_cur;
    logic [15:0] g_tgt;
    logic [2:0][ORD-1:0][15:0] hist;
    logic [ORD-1:0][15:0] lsf_p;
    logic [ORD-1:0][15:0] lsf_c;
    logic [ORD-1:0][15:0] lsf_tc;
    logic [31:0] nsum;
    logic [ORD:0][31:0] r;
    logic [ORD:0][31:0] a;
    logic [63:0] acc;
    logic [31:0] err;
    logic [4:0] li;
    logic [4:0] lj;
    logic [15:0] sidx;
    logic [15:0] ex_p;
    logic [15:0] ex_c;
    logic ex_v;
    logic done;
    logic lpc_v;
  } efc_reg_t;

  efc_reg_t r_ff;
  efc_reg_t nxt_r;

  // ==================================================
  // arithmetic helpers
  function automatic logic [15:0] mq(input logic [15:0] x,
                                     input logic [15:0] y);
    logic [31:0] p;
    p = 32'(x) * 32'(y);
    return p[29:14];
  endfunction

  function automatic logic [15:0] mix(input logic [15:0] al,
                                      input logic [15:0] old,
                                      input logic [15:0] tgt);
    return 16'(mq(al, old) + mq(`EFC_ONE - al, tgt));
  endfunction

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] q;
    logic [15:0] t;
    q = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      t = q | (16'h0001 << b);
      if (32'(t) * 32'(t) <= v) begin
        q = t;
      end
    end
    return q;
  endfunction

  // gain walks from g0 at index zero toward g1
  function automatic logic [15:0] fade(input logic [15:0] g0,
                                       input logic [15:0] g1,
                                       input logic [15:0] idx,
                                       input logic [15:0] s);
    logic signed [33:0] d;
    logic signed [33:0] rmp;
    logic signed [49:0] p;
    d = $signed({18'h00000, g0}) - $signed({18'h00000, g1});
    rmp = $signed({18'h00000, g0})
        - 34'((d * $signed({18'h00000, idx})) / FRAME_LEN);
    p = rmp * $signed(s);
    return p[29:14];
  endfunction

  // ==================================================
  // damping factor
  logic [15:0] sq;
  logic [15:0] a_base;
  logic [15:0] a_fin;
  logic [15:0] gp_new;
  logic [15:0] alpha_c;
  logic keep_cls;
  logic short_loss;

  always_comb begin
    sq = isqrt({2'h0, r_ff.gp, 14'h0000});
    if (sq < `EFC_SQ_MIN) begin
      sq = `EFC_SQ_MIN;
    end else if (sq > `EFC_SQ_MAX) begin
      sq = `EFC_SQ_MAX;
    end
    short_loss = r_ff.cnt <= `EFC_SHORT_LOSS;
    keep_cls = r_ff.cls != efc_pkg::unpitched_frame_class &&
               r_ff.cls != efc_pkg::unpitched_trans_class &&
               r_ff.cls != efc_pkg::voiced_trans_class;
    gp_new = r_ff.gp;
    a_base = `EFC_A040;
    if (r_ff.celp) begin
      if (r_ff.ctype == efc_pkg::coder_unvoiced && short_loss) begin
        a_base = `EFC_ONE;
      end else if (r_ff.cls == efc_pkg::unpitched_frame_class) begin
        if (r_ff.cnt == 4'h1) begin
          a_base = 16'(`EFC_A080 + mq(`EFC_A020, r_ff.theta));
        end else if (r_ff.cnt == 4'h2) begin
          a_base = `EFC_A060;
        end else begin
          a_base = `EFC_A040;
        end
      end else if (r_ff.cls == efc_pkg::unpitched_trans_class) begin
        a_base = `EFC_A080;
      end else if (r_ff.cls == efc_pkg::onset_class && short_loss &&
                   r_ff.ctype == efc_pkg::coder_generic) begin
        a_base = `EFC_A080;
      end else if (r_ff.cls == efc_pkg::periodic_frame_class ||
                   (r_ff.cls == efc_pkg::onset_class && short_loss)) begin
        a_base = `EFC_ONE;
      end else begin
        a_base = `EFC_A040;
      end
      a_fin = a_base;
      if (keep_cls) begin
        if (r_ff.cnt == 4'h1) begin
          a_fin = mq(a_base, sq);
        end else if (r_ff.cnt == 4'h2) begin
          a_fin = mq(16'(`EFC_A060 + mq(`EFC_A035, r_ff.theta)),
                     r_ff.gp);
        end else begin
          gp_new = mq(r_ff.gp,
                      16'(`EFC_A070 + mq(`EFC_A020, r_ff.theta)));
          a_fin = mq(a_base, gp_new);
        end
      end
    end else begin
      if (r_ff.cnt == 4'h1) begin
        a_fin = 16'(`EFC_A070 + mq(`EFC_A030, r_ff.theta));
      end else if (r_ff.cnt == 4'h2) begin
        a_fin = 16'(`EFC_A045 + mq(`EFC_A040, r_ff.theta));
      end else begin
        a_fin = 16'(`EFC_A035 + mq(`EFC_A040, r_ff.theta));
      end
    end
    // innovative envelope never fades faster than 0.8
    alpha_c = (r_ff.alpha < `EFC_A080) ? `EFC_A080 : r_ff.alpha;
  end

  // ==================================================
  // noise level and recursion arithmetic
  logic [23:0] esum;
  logic [15:0] e_avg;
  logic [15:0] g_raw;
  logic [31:0] bin_pow;
  logic signed [63:0] k_full;
  logic signed [31:0] k;
  logic signed [63:0] ek;

  always_comb begin
    esum = 24'h000000;
    for (int i = 0; i < NSUB; i++) begin
      esum = esum + 24'(subfr_energy[i]);
    end
    e_avg = 16'(esum / NSUB);
    g_raw = isqrt(32'((64'(r_ff.nsum) * `EFC_NOISE_NUM) / FRAME_LEN));
    bin_pow = 32'(bin_value) * 32'(bin_value);
    if (r_ff.err == 32'h00000000) begin
      k_full = 64'sh0;
    end else begin
      k_full = -$signed(r_ff.acc) / $signed({32'h00000000, r_ff.err});
    end
    k = k_full[31:0];
    ek = ($signed(r_ff.err) * k) >>> 14;
  end

  // ==================================================
  // frame sequencer
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.ex_v = exc_valid;
    if (exc_valid) begin
      nxt_r.ex_p = fade(r_ff.g_prev[0], r_ff.g_cur[0], r_ff.sidx,
                        exc_harm);
      nxt_r.ex_c = fade(r_ff.g_prev[1], r_ff.g_cur[1], r_ff.sidx,
                        exc_inno);
      nxt_r.sidx = r_ff.sidx + 16'h0001;
    end
    case (r_ff.fsm)
      efc_pkg::st_idle: begin
        // a frame arriving while busy is dropped
        if (frame_start) begin
          nxt_r.sidx = 16'h0000;
          nxt_r.cls = last_class;
          nxt_r.ctype = coder_type;
          nxt_r.celp = code_excited_core;
          nxt_r.theta = stability;
          nxt_r.gp = pitch_gain_in;
          if (frame_lost) begin
            if (r_ff.cnt != `EFC_CNT_MAX) begin
              nxt_r.cnt = r_ff.cnt + 4'h1;
            end
            nxt_r.fsm = efc_pkg::st_alpha;
          end else begin
            nxt_r.cnt = 4'h0;
            nxt_r.hist[2] = r_ff.hist[1];
            nxt_r.hist[1] = r_ff.hist[0];
            nxt_r.hist[0] = lsf_in;
            nxt_r.lsf_p = lsf_in;
            nxt_r.lsf_c = lsf_in;
            nxt_r.g_prev = gain_in;
            nxt_r.g_cur = gain_in;
            nxt_r.done = 1'b1;
          end
        end
      end
      efc_pkg::st_alpha: begin
        nxt_r.alpha = a_fin;
        nxt_r.gp = gp_new;
        nxt_r.nsum = 32'h00000000;
        nxt_r.r = '0;
        // targets are built once, in the first lost frame only
        nxt_r.fsm = (r_ff.cnt == 4'h1) ? efc_pkg::st_spec
                                       : efc_pkg::st_apply;
      end
      efc_pkg::st_spec: begin
        if (bin_valid) begin
          if (bin_index >= first_noise_bin &&
              bin_index <= last_noise_bin) begin
            nxt_r.nsum = r_ff.nsum + 32'(bin_value);
          end
          for (int j = 0; j <= ORD; j++) begin
            nxt_r.r[j] = 32'($signed(r_ff.r[j]) +
              ((64'($signed({1'b0, bin_pow})) * $signed(bin_cos[j]))
               >>> 15));
          end
          if (bin_last) begin
            nxt_r.fsm = efc_pkg::st_noise;
          end
        end
      end
      efc_pkg::st_noise: begin
        nxt_r.g_tgt = 16'((32'(g_raw) * 32'(e_avg)) >> 14);
        for (int j = 0; j <= ORD; j++) begin
          nxt_r.r[j] = 32'($signed(r_ff.r[j]) >>> NORM_SHIFT);
        end
        if ($signed(nxt_r.r[0]) < $signed(`EFC_R0_MIN)) begin
          nxt_r.r[0] = `EFC_R0_MIN;
        end
        nxt_r.r[0] = nxt_r.r[0] + nxt_r.r[0] / `EFC_R0_DIV;
        nxt_r.a = '0;
        nxt_r.a[0] = `EFC_COEF_ONE;
        nxt_r.err = nxt_r.r[0];
        nxt_r.li = 5'h01;
        nxt_r.lj = 5'h00;
        nxt_r.acc = 64'h0;
        nxt_r.fsm = efc_pkg::st_leva;
      end
      efc_pkg::st_leva: begin
        // one product per cycle keeps a single multiplier
        nxt_r.acc = 64'($signed(r_ff.acc) +
          $signed(r_ff.a[r_ff.lj]) *
          $signed(r_ff.r[5'(r_ff.li - r_ff.lj)]));
        if (r_ff.lj == 5'(r_ff.li - 5'h01)) begin
          nxt_r.fsm = efc_pkg::st_levk;
        end else begin
          nxt_r.lj = r_ff.lj + 5'h01;
        end
      end
      efc_pkg::st_levk: begin
        for (int j = 1; j <= ORD; j++) begin
          if (j < int'(r_ff.li)) begin
            nxt_r.a[j] = 32'($signed(r_ff.a[j]) +
              (($signed(r_ff.a[int'(r_ff.li) - j]) * k) >>> 14));
          end
        end
        nxt_r.a[r_ff.li] = k;
        nxt_r.err = 32'($signed(r_ff.err) - ((ek * k) >>> 14));
        if (int'(r_ff.li) == ORD) begin
          nxt_r.lpc_v = 1'b1;
          nxt_r.fsm = efc_pkg::st_lsfw;
        end else begin
          nxt_r.li = r_ff.li + 5'h01;
          nxt_r.lj = 5'h00;
          nxt_r.acc = 64'h0;
          nxt_r.fsm = efc_pkg::st_leva;
        end
      end
      efc_pkg::st_lsfw: begin
        if (lsf_tgt_valid) begin
          nxt_r.lsf_tc = lsf_tgt_in;
          nxt_r.lpc_v = 1'b0;
          nxt_r.fsm = efc_pkg::st_apply;
        end
      end
      efc_pkg::st_apply: begin
        nxt_r.g_prev = r_ff.g_cur;
        nxt_r.g_cur[0] = mix(r_ff.alpha, r_ff.g_cur[0], 16'h0000);
        nxt_r.g_cur[1] = mix(r_ff.alpha, r_ff.g_cur[1], r_ff.g_tgt);
        for (int j = 0; j < ORD; j++) begin
          nxt_r.lsf_p[j] = mix(r_ff.alpha, r_ff.lsf_p[j],
            16'((18'(r_ff.hist[0][j]) + 18'(r_ff.hist[1][j]) +
                 18'(r_ff.hist[2][j])) / `EFC_HIST_LEN));
          nxt_r.lsf_c[j] = mix(alpha_c, r_ff.lsf_c[j],
                               r_ff.lsf_tc[j]);
        end
        nxt_r.done = 1'b1;
        nxt_r.fsm = efc_pkg::st_idle;
      end
      default: begin
        nxt_r.fsm = efc_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign lost_count = r_ff.cnt;
  assign alpha = r_ff.alpha;
  assign pitch_gain = r_ff.gp;
  assign gain_harm = r_ff.g_cur[0];
  assign gain_inno = r_ff.g_cur[1];
  assign gain_target = r_ff.g_tgt;
  assign lsf_harm = r_ff.lsf_p;
  assign lsf_inno = r_ff.lsf_c;
  assign lpc_coef = r_ff.a;
  assign lpc_valid = r_ff.lpc_v;
  assign frame_done = r_ff.done;
  assign fade_valid = r_ff.ex_v;
  assign fade_harm = r_ff.ex_p;
  assign fade_inno = r_ff.ex_c;

  // ==================================================
  // checks
  a_good_clear: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_idle && frame_start && !frame_lost
    |=> lost_count == 4'h0 && frame_done)
    else $error("good frame did not clear loss count");
  a_lost_count: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_idle && frame_start && frame_lost &&
    r_ff.cnt != `EFC_CNT_MAX |=> lost_count == $past(lost_count) + 4'h1)
    else $error("lost frame did not advance loss count");
  a_harm_zero: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_apply
    |=> gain_harm == mq($past(alpha), $past(gain_harm)) && frame_done)
    else $error("harmonic gain not faded toward zero");
  a_unv_one: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_alpha && r_ff.celp && short_loss &&
    r_ff.ctype == efc_pkg::coder_unvoiced && !keep_cls
    |=> alpha == `EFC_ONE)
    else $error("unvoiced short loss damping not one");
  a_other_first: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_alpha && !r_ff.celp && r_ff.cnt == 4'h1
    |=> alpha == 16'(`EFC_A070 + mq(`EFC_A030, $past(r_ff.theta))))
    else $error("first loss damping wrong for other core");
  a_second_loss: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_alpha && r_ff.celp && r_ff.cnt == 4'h2 &&
    r_ff.cls == efc_pkg::periodic_frame_class
    |=> alpha == mq(16'(`EFC_A060 + mq(`EFC_A035, $past(r_ff.theta))),
                    $past(r_ff.gp)))
    else $error("second loss damping wrong");
  a_root_clamp: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_alpha && r_ff.celp && r_ff.cnt == 4'h1 &&
    r_ff.cls == efc_pkg::periodic_frame_class &&
    r_ff.ctype == efc_pkg::coder_generic
    |=> alpha >= `EFC_SQ_MIN && alpha <= `EFC_SQ_MAX)
    else $error("first loss root gain outside clamp");
  a_tgt_hold: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_alpha && r_ff.cnt != 4'h1
    |=> ##1 $stable(gain_target))
    else $error("noise target changed after first loss");
  a_r0_floor: assert property (@(posedge clock) disable iff (rst)
    r_ff.fsm == efc_pkg::st_noise
    |=> $signed(r_ff.err) >= $signed(`EFC_R0_MIN))
    else $error("lag zero below floor");
  a_ramp_start: assert property (@(posedge clock) disable iff (rst)
    exc_valid && r_ff.sidx == 16'h0000
    |=> fade_valid && fade_harm == fade($past(r_ff.g_prev[0]),
                                        $past(gain_harm), 16'h0000,
                                        $past(exc_harm)))
    else $error("ramp does not start at previous gain");
endmodule

// ==== verif/efc_dp_model.sv ====
`timescale 1ns/1ps
module efc_dp_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_start,
  input wire logic frame_lost,
  input wire logic [3:0] lost_count,
  input wire logic lpc_valid,
  output logic bin_valid,
  output logic bin_last,
  output logic [15:0] bin_index,
  output logic [15:0] bin_value,
  output logic [16:0][15:0] bin_cos,
  output logic lsf_tgt_valid,
  output logic [15:0][15:0] lsf_tgt_in
);
  int i;
  int k;
  // ==================================================
  // spectrum feed
  // only lag zero carries weight: upper lags stay zero, so the
  // recursion gives an exact identity filter while bins still vary
  initial begin
    bin_valid = 1'b0;
    bin_last = 1'b0;
    lsf_tgt_valid = 1'b0;
    for (k = 0; k < 16; k++) lsf_tgt_in[k] = 16'(32'h800 * (k + 1));
    forever begin
      bin_index = 16'($urandom);
      bin_value = 16'($urandom);
      bin_cos = {17{16'($urandom)}};
      @(posedge clock);
      if (rst === 1'b0 && frame_start && frame_lost &&
          lost_count == 4'h0) begin
        repeat ($urandom_range(3, 1)) @(posedge clock);
        for (k = 0; k < 8; k++) begin
          #1;
          bin_valid = 1'b1;
          bin_last = (k == 7);
          bin_index = 16'(k);
          bin_value = 16'($urandom_range(4095));
          bin_cos = '0;
          bin_cos[0] = 16'h7FFF;
          @(posedge clock);
        end
        #1;
        bin_valid = 1'b0;
        bin_last = 1'b0;
        for (i = 0; i < 600 && lpc_valid !== 1'b1; i++) @(posedge clock) #1;
        repeat ($urandom_range(2, 0)) @(posedge clock) #1;
        lsf_tgt_valid = 1'b1;
        @(posedge clock) #1;
        lsf_tgt_valid = 1'b0;
      end
      #1;
    end
  end
endmodule

// ==== verif/excitation_fade_control_tb.sv ====
`timescale 1ns/1ps
module excitation_fade_control_tb;
  localparam int L = 256;
  localparam int T = 24;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic frame_start = 0, frame_lost = 0, code_excited_core = 0;
  efc_pkg::efc_class_t last_class = efc_pkg::other_class;
  efc_pkg::efc_coder_t coder_type = efc_pkg::coder_generic;
  logic [15:0] stability = 0, pitch_gain_in = 0;
  logic [1:0][15:0] gain_in = '0;
  logic [15:0][15:0] lsf_in = '0, lsf_harm, lsf_inno, lsf_tgt_in;
  logic [3:0][15:0] subfr_energy = '0;
  logic [15:0] first_noise_bin = 16'h0000, last_noise_bin = 16'h0007;
  logic exc_valid = 0;
  logic [15:0] exc_harm = 0, exc_inno = 0, bin_index, bin_value;
  logic bin_valid, bin_last, lsf_tgt_valid, lpc_valid, frame_done;
  logic fade_valid;
  logic [16:0][15:0] bin_cos;
  logic [3:0] lost_count;
  logic [15:0] alpha, pitch_gain, gain_harm, gain_inno, gain_target;
  logic [15:0] fade_harm, fade_inno;
  logic [16:0][31:0] lpc_coef;
  int num_errors = 0, checks_done = 0, cnt = 0, j, n, ns = 0, ev = 0;
  int h[3][16];
  real gh, gi, th, gp, gt;
  real li[16];
  bit ce_t[9] = '{0, 1, 1, 1, 1, 1, 1, 1, 1};
  int cl_t[9] = '{5, 0, 1, 4, 3, 2, 2, 4, 5};
  int ct_t[9] = '{0, 0, 2, 0, 0, 0, 1, 2, 2};
  int nl_t[9] = '{3, 3, 2, 2, 2, 5, 4, 1, 3};

  always #2.5 clock = ~clock;

  // partner bins seen on the bus feed the noise level model
  always @(posedge clock) begin
    if (bin_valid === 1'b1 && bin_index >= first_noise_bin &&
        bin_index <= last_noise_bin) begin
      ns += int'(bin_value);
    end
  end

  efc_fade #(.FRAME_LEN(L)) uut (
    .clock, .rst, .frame_start, .frame_lost, .code_excited_core,
    .last_class, .coder_type, .stability, .pitch_gain_in, .gain_in,
    .lsf_in, .subfr_energy, .first_noise_bin, .last_noise_bin,
    .bin_valid, .bin_last, .bin_index, .bin_value, .bin_cos,
    .lsf_tgt_valid, .lsf_tgt_in, .exc_valid, .exc_harm, .exc_inno,
    .lost_count, .alpha, .pitch_gain, .gain_harm, .gain_inno,
    .gain_target, .lsf_harm, .lsf_inno, .lpc_coef, .lpc_valid,
    .frame_done, .fade_valid, .fade_harm, .fade_inno
  );

  efc_dp_model dp (
    .clock, .rst, .frame_start, .frame_lost, .lost_count, .lpc_valid,
    .bin_valid, .bin_last, .bin_index, .bin_value, .bin_cos,
    .lsf_tgt_valid, .lsf_tgt_in
  );

  // ==================================================
  // comparison and verdict
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e, int tol);
    int d;
    d = $signed(s) - $signed(e);
    checks_done++;
    if (s !== e && (tol == 0 || ^s === 1'bx || d > tol || d < -tol)) begin
      num_errors++;
      $display("mismatch %s exp %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic int q(real x);
    return $rtoi(x * 16384.0 + 0.5);
  endfunction

  // ==================================================
  // reference damping
  // pitch gain held through a loss run, so one decay step is unambiguous
  function automatic real m_alpha(bit ce, int c, int t, int k);
    real a;
    real r;
    if (!ce) begin
      if (k == 1) return 0.7 + 0.3 * th;
      if (k == 2) return 0.45 + 0.4 * th;
      return 0.35 + 0.4 * th;
    end
    if (t == 1 && k <= 3) a = 1.0;
    else if (c == 0) a = k == 1 ? 0.8 + 0.2 * th : k == 2 ? 0.6 : 0.4;
    else if (c == 1 || (c == 4 && k <= 3 && t == 0)) a = 0.8;
    else if (c == 3 || (c == 4 && k <= 3)) a = 1.0;
    else a = 0.4;
    if (c <= 2) return a;
    r = $sqrt(gp);
    r = r < 0.85 ? 0.85 : r > 0.98 ? 0.98 : r;
    if (k == 1) return a * r;
    if (k == 2) return (0.6 + 0.35 * th) * gp;
    gp = gp * (0.7 + 0.2 * th);
    return a * gp;
  endfunction

  // ==================================================
  // one frame, then model update and compare
  task automatic frame(bit lost);
    int i, k, sv;
    real a, ai, ph, pi, m;
    // an edge between frames keeps frame_start from being set twice at once
    @(posedge clock) #1;
    if (lost && cnt == 0) begin
      ns = 0;
      first_noise_bin = 16'($urandom_range(3));
      last_noise_bin = 16'($urandom_range(7, 4));
    end
    stability = 16'($urandom_range(16384));
    if (!lost) begin
      pitch_gain_in = 16'($urandom_range(16384, 8192));
      gain_in[0] = 16'($urandom_range(16384));
      gain_in[1] = 16'($urandom_range(16384));
      for (k = 0; k < 16; k++) lsf_in[k] = 16'($urandom_range(32767));
    end
    ev = int'($urandom_range(16384));
    subfr_energy = {4{16'(ev)}};
    {frame_start, frame_lost, code_excited_core} = {1'b1, lost, ce_t[j]};
    last_class = efc_pkg::efc_class_t'(cl_t[j]);
    coder_type = efc_pkg::efc_coder_t'(ct_t[j]);
    th = stability / 16384.0;
    gp = pitch_gain_in / 16384.0;
    @(posedge clock) #1;
    frame_start = 1'b0;
    for (i = 0; frame_done !== 1'b1; i++) begin
      if (i > 3000) begin
        num_errors++;
        test_done();
      end
      @(posedge clock) #1;
    end
    ph = gh;
    pi = gi;
    if (!lost) begin
      cnt = 0;
      gh = gain_in[0] / 16384.0;
      gi = gain_in[1] / 16384.0;
      chk("gain_harm", gain_harm, gain_in[0], 0);
      chk("gain_inno", gain_inno, gain_in[1], 0);
      for (k = 0; k < 16; k++) begin
        h[0][k] = h[1][k];
        h[1][k] = h[2][k];
        h[2][k] = lsf_in[k];
        li[k] = lsf_in[k];
        chk("lsf_harm", lsf_harm[k], lsf_in[k], 0);
      end
    end else begin
      cnt = cnt < 15 ? cnt + 1 : 15;
      a = m_alpha(ce_t[j], cl_t[j], ct_t[j], cnt);
      ai = a < 0.8 ? 0.8 : a;
      if (cnt == 1) gt = $sqrt(ns * 320.0 / L) * ev / 16384.0;
      gh = a * gh;
      gi = a * gi + (1.0 - a) * gt / 16384.0;
      chk("alpha", alpha, q(a), T);
      chk("gain_harm", gain_harm, q(gh), T);
      chk("gain_inno", gain_inno, q(gi), T);
      chk("gain_target", gain_target, $rtoi(gt), 3);
      chk("lpc_valid", lpc_valid, 0, 0);
      if (cnt == 3 && ce_t[j] && cl_t[j] == 5)
        chk("pitch_gain", pitch_gain, q(gp), T);
      for (k = 0; k < 16; k++) begin
        li[k] = ai * li[k] + (1.0 - ai) * 2048 * (k + 1);
        chk("lsf_inno", lsf_inno[k], $rtoi(li[k]), T);
        m = (h[0][k] + h[1][k] + h[2][k]) / 3.0;
        if (cnt == 1)
          chk("lsf_harm", lsf_harm[k],
              $rtoi(a * h[2][k] + (1 - a) * m), T);
      end
      for (k = 0; k < 17 && cnt == 1; k++)
        chk("lpc_coef", lpc_coef[k],
            k == 0 ? 32'h4000 : 32'h0, 0);
      for (i = 0; i < 2; i++) begin
        sv = int'($urandom_range(4094)) - 2047;
        exc_harm = 16'(sv);
        exc_inno = 16'(-sv);
        exc_valid = 1'b1;
        @(posedge clock) #1;
        chk("fade_valid", fade_valid, 1, 0);
        exc_valid = 1'b0;
        @(posedge clock) #1;
        chk("fade_valid", fade_valid, 0, 0);
        chk("fade_harm", {{16{fade_harm[15]}}, fade_harm},
            $rtoi(sv * (ph - i * (ph - gh) / L)), T);
        chk("fade_inno", {{16{fade_inno[15]}}, fade_inno},
            $rtoi(-sv * (pi - i * (pi - gi) / L)), T);
      end
    end
    chk("lost_count", lost_count, cnt, 0);
  endtask

  // ==================================================
  // main sequence: three good frames ahead of each loss run
  initial begin
    void'($urandom(96));
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("lost_count", lost_count, 0, 0);
    chk("alpha", alpha, 0, 0);
    chk("lpc_valid", lpc_valid, 0, 0);
    for (j = 0; j < 9; j++) begin
      repeat (3) frame(1'b0);
      for (n = 0; n < nl_t[j]; n++) frame(1'b1);
    end
    test_done();
  end
endmodule
